// ==== shared/ptap_consts.svh ====
// Constants for the program trace atom packer
`ifndef PTAP_CONSTS_SVH
`define PTAP_CONSTS_SVH

// Register byte offsets
`define PTAP_MAIN_CONTROL_OFS 12'h000
`define PTAP_TRIGGER_EVENT_OFS 12'h008
`define PTAP_TRACE_ENABLE_EVENT_OFS 12'h020
`define PTAP_TRACE_ENABLE_CONTROL_OFS 12'h024
`define PTAP_TIMESTAMP_EVENT_OFS 12'h0f8
`define PTAP_TRACE_SOURCE_ID_OFS 12'h200
`define PTAP_TRACE_SPACE_END 12'h300
`define PTAP_SAVE_LOCK_ACCESS_OFS 12'h300
`define PTAP_SAVE_LOCK_STATUS_OFS 12'h304
`define PTAP_SAVE_RESTORE_SEQ_OFS 12'h308
`define PTAP_POWER_DOWN_STATUS_OFS 12'h314
`define PTAP_INTEGRATION_MODE_OFS 12'hf00
`define PTAP_LOCK_ACCESS_OFS 12'hfb0
`define PTAP_LOCK_STATUS_OFS 12'hfb4
`define PTAP_AUTH_STATUS_OFS 12'hfb8
`define PTAP_DEVICE_CONFIG_ID_OFS 12'hfc8

// Main control fields
`define PTAP_MC_POWER_DOWN 0
`define PTAP_MC_BRANCH_BCAST 8
`define PTAP_MC_PROGRAMMING 10
`define PTAP_MC_CYCLE_ACC 12
`define PTAP_MC_TIMESTAMP 28
`define PTAP_MC_RESET 32'h0000_0401
// Bits of main control still writable while powered down
`define PTAP_MC_PD_MASK 32'h0000_0401

// Lock key and reset values
`define PTAP_UNLOCK_KEY 32'hc5ac_ce55
`define PTAP_SW_LOCK_RESET 1'b1
`define PTAP_SAVE_LOCK_RESET 1'b1
`define PTAP_LOCK_STATUS_IMPL 32'h0000_0001

// Packet encoding
`define PTAP_MAX_ATOMS 3'h5
`define PTAP_CA_MARK 8'h80
`define PTAP_BRANCH_HDR 8'h40
`define PTAP_PKT_BYTES 5
`define PTAP_ADDR_W 12

`endif

// ==== shared/ptap_pkg.sv ====
// Types for the program trace atom packer
package ptap_pkg;

    typedef enum logic [2:0]
    {
        ptap_cls_trace,
        ptap_cls_rsvd_trace,
        ptap_cls_save_lock,
        ptap_cls_ident,
        ptap_cls_lock_access,
        ptap_cls_unp_mgmt,
        ptap_cls_rsvd_mgmt
    } ptap_class_t;

    typedef enum logic [1:0]
    {
        ptap_bus_idle,
        ptap_bus_wait,
        ptap_bus_err
    } ptap_bus_t;

endpackage : ptap_pkg

// ==== logic/ptap_top.sv ====
// Program trace atom packer with gated register access
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ptap_consts.svh"

module ptap_top #(
    parameter logic [31:0] DEVICE_CONFIG_ID = 32'h0000_0000, // Arbitrary value
    parameter logic [31:0] AUTH_STATUS = 32'h0000_0000 // Arbitrary value
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic debug_power_up,
    input wire logic core_power_up,
    input wire logic software_debug_enable,
    input wire logic cpu_privileged,
    input wire logic trace_access_enable,
    input wire logic cp_req,
    input wire logic cp_write,
    input wire logic [11:0] cp_addr,
    input wire logic [31:0] cp_wdata,
    output logic cp_done,
    output logic cp_err,
    output logic cp_impossible,
    output logic [31:0] cp_rdata,
    input wire logic commit_valid,
    input wire logic commit_is_isb,
    input wire logic commit_taken,
    input wire logic [31:0] commit_target,
    input wire logic flush_req,
    output logic commit_ready,
    output logic trace_valid,
    output logic [7:0] trace_data
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    function automatic ptap_pkg::ptap_class_t classify(input logic [11:0] a);
        ptap_pkg::ptap_class_t c;
        if (a == `PTAP_MAIN_CONTROL_OFS || a == `PTAP_TRIGGER_EVENT_OFS ||
            a == `PTAP_TRACE_ENABLE_EVENT_OFS || a == `PTAP_TRACE_ENABLE_CONTROL_OFS ||
            a == `PTAP_TIMESTAMP_EVENT_OFS || a == `PTAP_TRACE_SOURCE_ID_OFS)
            c = ptap_pkg::ptap_cls_trace;
        else if (a < `PTAP_TRACE_SPACE_END)
            c = ptap_pkg::ptap_cls_rsvd_trace;
        else if (a == `PTAP_SAVE_LOCK_ACCESS_OFS || a == `PTAP_SAVE_LOCK_STATUS_OFS)
            c = ptap_pkg::ptap_cls_save_lock;
        else if (a == `PTAP_DEVICE_CONFIG_ID_OFS || a == `PTAP_AUTH_STATUS_OFS)
            c = ptap_pkg::ptap_cls_ident;
        else if (a == `PTAP_LOCK_ACCESS_OFS)
            c = ptap_pkg::ptap_cls_lock_access;
        else if (a == `PTAP_LOCK_STATUS_OFS || a == `PTAP_POWER_DOWN_STATUS_OFS ||
                 a == `PTAP_SAVE_RESTORE_SEQ_OFS || a == `PTAP_INTEGRATION_MODE_OFS)
            c = ptap_pkg::ptap_cls_unp_mgmt;
        else
            c = ptap_pkg::ptap_cls_rsvd_mgmt;
        return c;
    endfunction : classify

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0] main_control_ff;
    logic [31:0] trigger_event_ff;
    logic [31:0] trace_enable_event_ff;
    logic [31:0] trace_enable_control_ff;
    logic [31:0] timestamp_event_ff;
    logic [31:0] trace_source_id_ff;
    logic [31:0] integration_mode_ff;
    logic sw_lock_ff;
    logic save_lock_ff;
    logic pd_sticky_ff;

    function automatic logic [31:0] read_reg(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h0;
        if (a == `PTAP_MAIN_CONTROL_OFS) v = main_control_ff;
        else if (a == `PTAP_TRIGGER_EVENT_OFS) v = trigger_event_ff;
        else if (a == `PTAP_TRACE_ENABLE_EVENT_OFS) v = trace_enable_event_ff;
        else if (a == `PTAP_TRACE_ENABLE_CONTROL_OFS) v = trace_enable_control_ff;
        else if (a == `PTAP_TIMESTAMP_EVENT_OFS) v = timestamp_event_ff;
        else if (a == `PTAP_TRACE_SOURCE_ID_OFS) v = trace_source_id_ff;
        else if (a == `PTAP_SAVE_LOCK_STATUS_OFS) v = {31'h0, save_lock_ff};
        else if (a == `PTAP_POWER_DOWN_STATUS_OFS) v = {31'h0, pd_sticky_ff};
        else if (a == `PTAP_INTEGRATION_MODE_OFS) v = integration_mode_ff;
        else if (a == `PTAP_LOCK_STATUS_OFS) v = `PTAP_LOCK_STATUS_IMPL | {30'h0, sw_lock_ff, 1'b0};
        else if (a == `PTAP_AUTH_STATUS_OFS) v = AUTH_STATUS;
        else if (a == `PTAP_DEVICE_CONFIG_ID_OFS) v = DEVICE_CONFIG_ID;
        return v;
    endfunction : read_reg

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    ptap_pkg::ptap_bus_t bus_state_ff;
    logic [11:0] bus_addr_ff;
    logic bus_write_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic [31:0] hrdata_ff;
    logic bus_accept;
    logic bus_no_power;
    logic bus_done;
    ptap_pkg::ptap_class_t bus_cls;

    assign bus_accept = hsel && htrans[1] && hready;
    assign bus_no_power = !debug_power_up || !software_debug_enable;
    assign bus_cls = classify(bus_addr_ff);
    assign bus_done = (bus_state_ff == ptap_pkg::ptap_bus_wait) && !bus_no_power;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state_ff <= ptap_pkg::ptap_bus_idle;
            bus_addr_ff <= 12'h0;
            bus_write_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            hrdata_ff <= 32'h0;
        end
        else
        begin
            case (bus_state_ff)
                ptap_pkg::ptap_bus_idle:
                begin
                    hresp_ff <= 1'b0;
                    if (bus_accept)
                    begin
                        bus_addr_ff <= {haddr[11:2], 2'b00};
                        bus_write_ff <= hwrite;
                        hreadyout_ff <= 1'b0;
                        bus_state_ff <= ptap_pkg::ptap_bus_wait;
                    end
                end
                ptap_pkg::ptap_bus_wait:
                begin
                    if (bus_no_power)
                    begin
                        hresp_ff <= 1'b1;
                        bus_state_ff <= ptap_pkg::ptap_bus_err;
                    end
                    else
                    begin
                        hreadyout_ff <= 1'b1;
                        hrdata_ff <= bus_write_ff ? 32'h0 : read_reg(bus_addr_ff);
                        bus_state_ff <= ptap_pkg::ptap_bus_idle;
                    end
                end
                default:
                begin
                    hreadyout_ff <= 1'b1;
                    bus_state_ff <= ptap_pkg::ptap_bus_idle;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Coprocessor path
    // ------------------------------------------------------------
    logic cp_nonpriv;
    logic cp_ok;
    ptap_pkg::ptap_class_t cp_cls;
    logic cp_done_ff;
    logic cp_err_ff;
    logic cp_impossible_ff;
    logic [31:0] cp_rdata_ff;

    assign cp_cls = classify({cp_addr[11:2], 2'b00});
    // Debug power is not looked at here, so state survives partial power-down
    assign cp_nonpriv = !cpu_privileged && !trace_access_enable;
    assign cp_ok = cp_req && core_power_up && !cp_nonpriv;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cp_done_ff <= 1'b0;
            cp_err_ff <= 1'b0;
            cp_impossible_ff <= 1'b0;
            cp_rdata_ff <= 32'h0;
        end
        else
        begin
            cp_done_ff <= cp_req;
            cp_impossible_ff <= cp_req && !core_power_up;
            cp_err_ff <= cp_req && core_power_up && cp_nonpriv;
            if (cp_ok && !cp_write && (cp_cls == ptap_pkg::ptap_cls_trace ||
                cp_cls == ptap_pkg::ptap_cls_save_lock || cp_cls == ptap_pkg::ptap_cls_ident))
                cp_rdata_ff <= read_reg({cp_addr[11:2], 2'b00});
            else
                cp_rdata_ff <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    logic wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    ptap_pkg::ptap_class_t wr_cls;
    logic wr_from_bus;
    logic trace_wr_ok;

    // Bus wins a same-cycle clash; coprocessor writes to the lock register never land
    always_comb
    begin
        wr_from_bus = bus_done && bus_write_ff;
        wr_en = 1'b0;
        wr_addr = bus_addr_ff;
        wr_data = hwdata;
        if (wr_from_bus)
        begin
            // Protected registers ignore writes under the software lock
            wr_en = !(sw_lock_ff && (bus_cls == ptap_pkg::ptap_cls_trace ||
                      bus_addr_ff == `PTAP_SAVE_LOCK_ACCESS_OFS ||
                      bus_cls == ptap_pkg::ptap_cls_unp_mgmt));
        end
        else if (cp_ok && cp_write && cp_cls != ptap_pkg::ptap_cls_lock_access)
        begin
            wr_en = 1'b1;
            wr_addr = {cp_addr[11:2], 2'b00};
            wr_data = cp_wdata;
        end
    end

    assign wr_cls = classify(wr_addr);
    assign trace_wr_ok = save_lock_ff || !main_control_ff[`PTAP_MC_POWER_DOWN];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            main_control_ff <= `PTAP_MC_RESET;
            trigger_event_ff <= 32'h0;
            trace_enable_event_ff <= 32'h0;
            trace_enable_control_ff <= 32'h0;
            timestamp_event_ff <= 32'h0;
            trace_source_id_ff <= 32'h0;
        end
        else if (wr_en && wr_cls == ptap_pkg::ptap_cls_trace)
        begin
            if (wr_addr == `PTAP_MAIN_CONTROL_OFS)
            begin
                if (trace_wr_ok)
                    main_control_ff <= wr_data;
                else
                    main_control_ff <= (main_control_ff & ~`PTAP_MC_PD_MASK) | (wr_data & `PTAP_MC_PD_MASK);
            end
            else if (trace_wr_ok)
            begin
                if (wr_addr == `PTAP_TRIGGER_EVENT_OFS) trigger_event_ff <= wr_data;
                if (wr_addr == `PTAP_TRACE_ENABLE_EVENT_OFS) trace_enable_event_ff <= wr_data;
                if (wr_addr == `PTAP_TRACE_ENABLE_CONTROL_OFS) trace_enable_control_ff <= wr_data;
                if (wr_addr == `PTAP_TIMESTAMP_EVENT_OFS) timestamp_event_ff <= wr_data;
                if (wr_addr == `PTAP_TRACE_SOURCE_ID_OFS) trace_source_id_ff <= wr_data;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sw_lock_ff <= `PTAP_SW_LOCK_RESET;
            save_lock_ff <= `PTAP_SAVE_LOCK_RESET;
            integration_mode_ff <= 32'h0;
        end
        else if (wr_en)
        begin
            if (wr_from_bus && wr_addr == `PTAP_LOCK_ACCESS_OFS)
                sw_lock_ff <= (wr_data != `PTAP_UNLOCK_KEY);
            if (wr_addr == `PTAP_SAVE_LOCK_ACCESS_OFS)
                save_lock_ff <= (wr_data == `PTAP_UNLOCK_KEY);
            if (wr_from_bus && wr_addr == `PTAP_INTEGRATION_MODE_OFS)
                integration_mode_ff <= wr_data;
        end
    end

    // Sticky power-down: a new power loss beats a clearing read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pd_sticky_ff <= 1'b1;
        else if (!core_power_up)
            pd_sticky_ff <= 1'b1;
        else if (bus_done && !bus_write_ff && bus_addr_ff == `PTAP_POWER_DOWN_STATUS_OFS && !sw_lock_ff)
            pd_sticky_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // Atom packer
    // ------------------------------------------------------------
    logic tracing;
    logic cyc_acc;
    logic [4:0] atoms_ff;
    logic [2:0] atom_cnt_ff;
    logic [31:0] cyc_cnt_ff;
    logic branch_pend_ff;
    logic [31:0] branch_addr_ff;
    logic flush_pend_ff;
    logic [7:0] out_buf_ff [`PTAP_PKT_BYTES];
    logic [2:0] out_len_ff;
    logic [2:0] out_idx_ff;
    logic commit_ready_ff;
    logic trace_valid_ff;
    logic [7:0] trace_data_ff;
    logic commit_take;
    logic out_idle;

    assign tracing = !main_control_ff[`PTAP_MC_POWER_DOWN] && !main_control_ff[`PTAP_MC_PROGRAMMING];
    assign cyc_acc = main_control_ff[`PTAP_MC_CYCLE_ACC];
    assign commit_take = commit_valid && commit_ready_ff && tracing;
    assign out_idle = (out_len_ff == 3'h0);

    // Normal atom header: marker bit just above the last atom, bit 7 clear
    function automatic logic [7:0] atom_hdr(input logic [4:0] a, input logic [2:0] n);
        logic [7:0] h;
        h = {3'b000, a} & ((8'h1 << n) - 8'h1);
        h = h | (8'h1 << n);
        return h;
    endfunction : atom_hdr

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            atoms_ff <= 5'h0;
            atom_cnt_ff <= 3'h0;
            cyc_cnt_ff <= 32'h0;
            branch_pend_ff <= 1'b0;
            branch_addr_ff <= 32'h0;
            flush_pend_ff <= 1'b0;
            out_len_ff <= 3'h0;
            out_idx_ff <= 3'h0;
            for (int i = 0; i < `PTAP_PKT_BYTES; i++)
                out_buf_ff[i] <= 8'h0;
        end
        else
        begin
            if (cyc_acc && tracing && cyc_cnt_ff != 32'hffff_ffff)
                cyc_cnt_ff <= cyc_cnt_ff + 32'h1;
            if (flush_req)
                flush_pend_ff <= 1'b1;
            if (!out_idle)
            begin
                out_idx_ff <= out_idx_ff + 3'h1;
                out_len_ff <= out_len_ff - 3'h1;
            end
            else if (branch_pend_ff || (flush_pend_ff && atom_cnt_ff != 3'h0))
            begin
                out_idx_ff <= 3'h0;
                if (atom_cnt_ff != 3'h0)
                begin
                    out_buf_ff[0] <= atom_hdr(atoms_ff, atom_cnt_ff);
                    out_len_ff <= 3'h1;
                    atom_cnt_ff <= 3'h0;
                    atoms_ff <= 5'h0;
                end
                else
                begin
                    out_buf_ff[0] <= `PTAP_BRANCH_HDR;
                    for (int i = 1; i < `PTAP_PKT_BYTES; i++)
                        out_buf_ff[i] <= branch_addr_ff[8*(i-1) +: 8];
                    out_len_ff <= 3'(`PTAP_PKT_BYTES);
                    branch_pend_ff <= 1'b0;
                end
            end
            else
            begin
                if (flush_pend_ff && !flush_req)
                    flush_pend_ff <= 1'b0;
                if (commit_take)
                begin
                    out_idx_ff <= 3'h0;
                    if (commit_is_isb && commit_taken && main_control_ff[`PTAP_MC_BRANCH_BCAST])
                    begin
                        branch_pend_ff <= 1'b1;
                        branch_addr_ff <= commit_target;
                    end
                    else if (cyc_acc)
                    begin
                        // One atom plus its cycle count, seven count bits per extension
                        out_buf_ff[0] <= `PTAP_CA_MARK | {1'b0, cyc_cnt_ff[31:5] != 27'h0, cyc_cnt_ff[4:0],
                                         commit_taken};
                        out_len_ff <= 3'h1;
                        for (int i = 1; i < `PTAP_PKT_BYTES; i++)
                        begin
                            out_buf_ff[i] <= {(cyc_cnt_ff >> (5 + 7 * i)) != 32'h0,
                                              7'(cyc_cnt_ff >> (5 + 7 * (i - 1)))};
                            if ((cyc_cnt_ff >> (5 + 7 * (i - 1))) != 32'h0)
                                out_len_ff <= 3'(i + 1);
                        end
                        cyc_cnt_ff <= 32'h0;
                    end
                    else if (atom_cnt_ff == `PTAP_MAX_ATOMS - 3'h1)
                    begin
                        out_buf_ff[0] <= atom_hdr(atoms_ff | ({4'h0, commit_taken} << atom_cnt_ff),
                                                  `PTAP_MAX_ATOMS);
                        out_len_ff <= 3'h1;
                        atom_cnt_ff <= 3'h0;
                        atoms_ff <= 5'h0;
                    end
                    else
                    begin
                        atoms_ff <= atoms_ff | ({4'h0, commit_taken} << atom_cnt_ff);
                        atom_cnt_ff <= atom_cnt_ff + 3'h1;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Stream output
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trace_valid_ff <= 1'b0;
            trace_data_ff <= 8'h0;
            commit_ready_ff <= 1'b0;
        end
        else
        begin
            trace_valid_ff <= !out_idle;
            trace_data_ff <= out_idle ? 8'h0 : out_buf_ff[out_idx_ff];
            // Conservative: stalls a cycle after each accepted commit so packets never overlap
            commit_ready_ff <= out_idle && !branch_pend_ff && !flush_pend_ff && !commit_take && !flush_req;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;
    assign cp_done = cp_done_ff;
    assign cp_err = cp_err_ff;
    assign cp_impossible = cp_impossible_ff;
    assign cp_rdata = cp_rdata_ff;
    assign commit_ready = commit_ready_ff;
    assign trace_valid = trace_valid_ff;
    assign trace_data = trace_data_ff;

endmodule : ptap_top

// ==== sim/ptap_top_checker.sv ====
// Port assertions for the trace atom packer
`timescale 1ns/1ps
`include "ptap_consts.svh"
module ptap_top_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic debug_power_up,
    input wire logic software_debug_enable,
    input wire logic core_power_up,
    input wire logic cpu_privileged,
    input wire logic trace_access_enable,
    input wire logic cp_req,
    input wire logic cp_write,
    input wire logic [11:0] cp_addr,
    input wire logic cp_done,
    input wire logic cp_err,
    input wire logic cp_impossible,
    input wire logic [31:0] cp_rdata,
    input wire logic trace_valid,
    input wire logic [7:0] trace_data
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic dbg_ok = debug_power_up && software_debug_enable;
    wire logic cp_ok = core_power_up && (cpu_privileged || trace_access_enable);
    sequence s_take; hsel && htrans[1] && hreadyout; endsequence
    sequence s_err_resp; !hreadyout ##1 (hresp && !hreadyout) ##1 hreadyout; endsequence
    property p_bus_err; s_take ##1 !dbg_ok |-> s_err_resp; endproperty
    property p_bus_ok; s_take ##1 dbg_ok |-> !hreadyout ##1 (hreadyout && !hresp); endproperty
    property p_cp_done; cp_req |=> cp_done; endproperty
    property p_cp_imp; cp_req && !core_power_up |=> cp_impossible && !cp_err && cp_rdata == 32'h0; endproperty
    property p_cp_err; cp_req && core_power_up && !cp_ok |=> cp_err && !cp_impossible; endproperty
    property p_cp_perm; cp_req && cp_ok |=> !cp_err && !cp_impossible; endproperty
    property p_cp_lar; cp_req && !cp_write && cp_addr == `PTAP_LOCK_ACCESS_OFS |=> cp_rdata == 32'h0; endproperty
    property p_hdr; trace_valid && !$past(trace_valid) && trace_data[7:6] == 2'h0 |-> trace_data != 8'h0; endproperty
    a_bus_err: assert property (p_bus_err) else $error("bus error reply missing");
    a_bus_ok: assert property (p_bus_ok) else $error("bus okay reply wrong");
    a_cp_done: assert property (p_cp_done) else $error("cp done missing");
    a_cp_imp: assert property (p_cp_imp) else $error("cp not flagged impossible");
    a_cp_err: assert property (p_cp_err) else $error("cp error missing");
    a_cp_perm: assert property (p_cp_perm) else $error("cp refused wrongly");
    a_cp_lar: assert property (p_cp_lar) else $error("lock access visible to cp");
    a_hdr: assert property (p_hdr) else $error("atom header without atoms");
endmodule : ptap_top_checker

bind ptap_top ptap_top_checker chk (.*);

// ==== sim/ptap_trace_sink.sv ====
// Trace capture model recording every stream byte
`timescale 1ns/1ps
module ptap_trace_sink (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic trace_valid,
    input wire logic [7:0] trace_data
);
    logic [7:0] q [$];
    // Always accepts: the stream has no back-pressure
    always @(posedge hclk)
        if (hresetn && trace_valid)
            q.push_back(trace_data);
endmodule : ptap_trace_sink

// ==== sim/ptap_top_bench.sv ====
// Self-checking bench for the trace atom packer
`timescale 1ns/1ps
`include "ptap_consts.svh"
module ptap_top_bench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, dbg = 1'b1, core = 1'b1, swen = 1'b1;
    logic priv = 1'b1, tae = 1'b1, cp_req = 1'b0, cp_write = 1'b0, cv = 1'b0, isb = 1'b0, tk = 1'b0, flush = 1'b0;
    logic hresp, hreadyout, cp_done, cp_err, cp_imp, tv, cr, e;
    logic [1:0] htrans = 2'h0;
    logic [11:0] cp_addr = 12'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, tgt = 32'h0, cp_wdata = 32'h0, rd, hrdata, cp_rdata;
    logic [7:0] td;
    logic [7:0] bx [6] = '{8'h40, 8'h78, 8'h56, 8'h34, 8'h12, 8'h02};
    int fail_count = 0, num_checks = 0;
    ptap_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .debug_power_up(dbg), .core_power_up(core), .software_debug_enable(swen), .cpu_privileged(priv),
        .trace_access_enable(tae), .cp_req(cp_req), .cp_write(cp_write), .cp_addr(cp_addr), .cp_wdata(cp_wdata),
        .cp_done(cp_done), .cp_err(cp_err), .cp_impossible(cp_imp), .cp_rdata(cp_rdata), .commit_valid(cv),
        .commit_is_isb(isb), .commit_taken(tk), .commit_target(tgt), .flush_req(flush), .commit_ready(cr),
        .trace_valid(tv), .trace_data(td));
    ptap_trace_sink sink (.hclk(hclk), .hresetn(hresetn), .trace_valid(tv), .trace_data(td));
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : ck
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x, input logic ex);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (!hreadyout);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
        e = hresp;
        ck(e, ex);
        if (!w && !ex)
            ck(rd, x);
    endtask : acc
    task automatic cpa(input logic w, input logic [11:0] a, input logic [31:0] x, input logic [1:0] fx);
        @(posedge hclk);
        cp_req <= 1'b1;
        cp_write <= w;
        cp_addr <= a;
        cp_wdata <= x;
        @(posedge hclk);
        cp_req <= 1'b0;
        @(posedge hclk);
        ck({cp_done, cp_imp, cp_err}, {1'b1, fx});
        if (!w)
            ck(cp_rdata, x);
    endtask : cpa
    task automatic cm(input logic t, input logic b);
        @(posedge hclk);
        cv <= 1'b1;
        tk <= t;
        isb <= b;
        do @(posedge hclk); while (!cr);
        cv <= 1'b0;
    endtask : cm
    task automatic fl();
        repeat (10) @(posedge hclk);
        flush <= 1'b1;
        @(posedge hclk);
        flush <= 1'b0;
        repeat (10) @(posedge hclk);
    endtask : fl
    task automatic t_bus();
        dbg <= 1'b0;
        acc(0, `PTAP_MAIN_CONTROL_OFS, 0, 0, 1);
        acc(1, 12'h2fc, 32'h1, 0, 1);
        dbg <= 1'b1;
        swen <= 1'b0;
        acc(0, `PTAP_LOCK_STATUS_OFS, 0, 0, 1);
        swen <= 1'b1;
        acc(1, `PTAP_MAIN_CONTROL_OFS, 0, 0, 0);
        acc(0, `PTAP_MAIN_CONTROL_OFS, 0, `PTAP_MC_RESET, 0);
        acc(0, 12'h2fc, 0, 0, 0);
        repeat (2) acc(0, `PTAP_POWER_DOWN_STATUS_OFS, 0, 1, 0);
        acc(1, `PTAP_LOCK_ACCESS_OFS, `PTAP_UNLOCK_KEY, 0, 0);
        $display("bus gating test done");
    endtask : t_bus
    task automatic t_cp();
        priv <= 1'b0;
        tae <= 1'b0;
        cpa(0, `PTAP_SAVE_LOCK_STATUS_OFS, 0, 2'h1);
        tae <= 1'b1;
        dbg <= 1'b0;
        cpa(1, `PTAP_TRIGGER_EVENT_OFS, 32'h5, 2'h0);
        cpa(0, `PTAP_TRIGGER_EVENT_OFS, 32'h5, 2'h0);
        dbg <= 1'b1;
        priv <= 1'b1;
        cpa(1, `PTAP_LOCK_ACCESS_OFS, 32'h0, 2'h0);
        cpa(0, `PTAP_LOCK_ACCESS_OFS, 32'h0, 2'h0);
        core <= 1'b0;
        cpa(0, `PTAP_TRIGGER_EVENT_OFS, 0, 2'h2);
        core <= 1'b1;
        $display("coprocessor test done");
    endtask : t_cp
    task automatic t_trace();
        acc(1, `PTAP_TRACE_ENABLE_CONTROL_OFS, 32'h0100_0000, 0, 0);
        acc(1, `PTAP_TRACE_ENABLE_EVENT_OFS, 32'h6f, 0, 0);
        acc(1, `PTAP_TRACE_SOURCE_ID_OFS, 32'h10, 0, 0);
        acc(1, `PTAP_MAIN_CONTROL_OFS, 0, 0, 0);
        acc(0, `PTAP_MAIN_CONTROL_OFS, 0, 0, 0);
        cm(1, 0);
        cm(0, 0);
        cm(1, 0);
        cm(1, 0);
        cm(0, 0);
        repeat (10) @(posedge hclk);
        ck(sink.q[0], 8'h2d);
        cm(1, 0);
        cm(0, 0);
        fl();
        ck(sink.q[1], 8'h05);
        acc(1, `PTAP_MAIN_CONTROL_OFS, 32'h100, 0, 0);
        tgt <= 32'h1234_5678;
        cm(1, 1);
        cm(0, 1);
        fl();
        foreach (bx[i])
            ck(sink.q[i + 2], bx[i]);
        ck(sink.q.size(), 8);
        acc(1, `PTAP_TIMESTAMP_EVENT_OFS, 32'h6f, 0, 0);
        acc(1, `PTAP_MAIN_CONTROL_OFS, 32'h1000_1000, 0, 0);
        cm(1, 0);
        fl();
        ck(sink.q[8] & 8'h81, `PTAP_CA_MARK | 8'h1);
        $display("atom packing test done");
    endtask : t_trace
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial
    begin
        forever #12.5 hclk = ~hclk;
    end
    // Generous bound: the whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        t_bus();
        t_cp();
        t_trace();
        give_verdict();
    end
endmodule : ptap_top_bench
